// file: src/tbf_top.v
// Two-port TDM bit-clock generator and framer initialisation sequencer.
// Assumes a framer register write port taking one write per ack.
// Summary of operation
// - Transmit bit clock rate equals clock divided by (divider plus one) times prescale.
// - Divider field sits in control bits 12 down to 1.
// - Control bit 0 selects prescale of 1 or 16.
// - Each port carries data and clock in both directions; both syncs run framer to host.
// - Two ports, each T1 or E1 fixed by a build-time parameter.
// - First init step writes 0x04 to framer control two.
// - Framer has no reset, so all its registers but control two get cleared.
// - Both sync lines are framer outputs accepted as host inputs.
`timescale 1ns/1ps
`include "tbf_consts.vh"
module tbf_top #(
	parameter PORT_A_E1 = 0,
	parameter PORT_B_E1 = 0,
	// Settle time in clocks; shorten only in simulation
	parameter [`TBF_WAIT_W-1:0] WAIT_CYCLES = `TBF_WAIT_CYCLES_DEF
) (
	// Clock and reset
	input wire clk_in,
	input wire reset_in,
	// Bit clock control per port
	input wire [`TBF_CTRL_W-1:0] ctrl_a_in,
	input wire [`TBF_CTRL_W-1:0] ctrl_b_in,
	// Host TDM side per port
	input wire [1:0] host_tdm_tx_data_in,
	output reg [1:0] host_tdm_rx_data_out,
	output reg [1:0] host_tdm_rx_sync_out,
	output reg [1:0] host_tdm_tx_sync_out,
	output reg [1:0] host_tdm_rx_clock_out,
	// Framer TDM side per port
	output reg [1:0] transmit_serial_data_out,
	output reg [1:0] transmit_bit_clock_out,
	input wire [1:0] receive_serial_data_in,
	input wire [1:0] receive_bit_clock_in,
	input wire [1:0] receive_frame_sync_in,
	input wire [1:0] transmit_frame_sync_in,
	// Init sequencer control
	input wire init_start_in,
	input wire settings_done_in,
	// Framer register write port
	output reg fr_wr_out,
	output reg [`TBF_ADDR_W-1:0] fr_addr_out,
	output reg [`TBF_DATA_W-1:0] fr_data_out,
	input wire fr_ack_in,
	// Status
	output reg wait_settings_out,
	output reg init_done_out,
	output reg [1:0] port_e1_out
);
	// Sequencer states, one per framer init step:
	// idle waits for a start request,
	// fallback writes control two with the clock-loss fallback bit,
	// wait lets the framer settle before anything else is touched,
	// zero sweeps every framer register, keeping only the fallback bit,
	// settings hands the framer to the host for its own setup,
	// the two line reset states pulse the line interface reset bit,
	// done holds the completion flag until a new start request.
	localparam ST_IDLE = 3'h0;
	localparam ST_FALLBACK = 3'h1;
	localparam ST_WAIT = 3'h2;
	localparam ST_ZERO = 3'h3;
	localparam ST_SETTINGS = 3'h4;
	localparam ST_LINE_INTERFACE_RESET_SET = 3'h5;
	localparam ST_LINE_INTERFACE_RESET_CLR = 3'h6;
	localparam ST_DONE = 3'h7;

	// Control words gathered so the generate loop can index them
	wire [`TBF_CTRL_W-1:0] ctrl_w [0:1];
	wire [1:0] bclk;
	assign ctrl_w[0] = ctrl_a_in;
	assign ctrl_w[1] = ctrl_b_in;

	// One bit clock generator per port drives the transmit clock
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
			tbf_div i_tbf_div (
				.clk_in(clk_in),
				.reset_in(reset_in),
				.ctrl_in(ctrl_w[gi]),
				.bit_clk_out(bclk[gi]),
				.bit_tick_out()
			);
			// Data passed in both directions, rx clock and both syncs toward the host, all registered
			always @(posedge clk_in) begin
				if (reset_in) begin
					transmit_serial_data_out[gi] <= 1'b0;
					transmit_bit_clock_out[gi] <= 1'b0;
					host_tdm_rx_data_out[gi] <= 1'b0;
					host_tdm_rx_clock_out[gi] <= 1'b0;
					host_tdm_rx_sync_out[gi] <= 1'b0;
					host_tdm_tx_sync_out[gi] <= 1'b0;
				end else begin
					transmit_serial_data_out[gi] <= host_tdm_tx_data_in[gi];
					transmit_bit_clock_out[gi] <= bclk[gi];
					host_tdm_rx_data_out[gi] <= receive_serial_data_in[gi];
					host_tdm_rx_clock_out[gi] <= receive_bit_clock_in[gi];
					host_tdm_rx_sync_out[gi] <= receive_frame_sync_in[gi];
					host_tdm_tx_sync_out[gi] <= transmit_frame_sync_in[gi];
				end
			end
		end
	endgenerate

	// Sequencer state, settle counter and sweep address
	reg [2:0] state_reg;
	reg [`TBF_WAIT_W-1:0] wait_reg;
	reg [`TBF_ADDR_W-1:0] addr_reg;

	// Init sequencer; one write outstanding at a time, held until acked
	always @(posedge clk_in) begin
		if (reset_in) begin
			state_reg <= ST_IDLE;
			wait_reg <= {`TBF_WAIT_W{1'b0}};
			addr_reg <= {`TBF_ADDR_W{1'b0}};
			fr_wr_out <= 1'b0;
			fr_addr_out <= {`TBF_ADDR_W{1'b0}};
			fr_data_out <= {`TBF_DATA_W{1'b0}};
			wait_settings_out <= 1'b0;
			init_done_out <= 1'b0;
			port_e1_out <= 2'h0;
		end else begin
			// Build-time port type, refreshed every cycle
			port_e1_out <= {PORT_B_E1 != 0, PORT_A_E1 != 0};
			case (state_reg)
			// Start request launches the fallback write
			ST_IDLE: begin
				if (init_start_in) begin
					init_done_out <= 1'b0;
					fr_wr_out <= 1'b1;
					fr_addr_out <= `TBF_CTRL_TWO_ADDR;
					fr_data_out <= `TBF_FALLBACK_VAL;
					state_reg <= ST_FALLBACK;
				end
			end
			// Fallback write held until the framer accepts it
			ST_FALLBACK: begin
				if (fr_ack_in) begin
					fr_wr_out <= 1'b0;
					wait_reg <= {`TBF_WAIT_W{1'b0}};
					state_reg <= ST_WAIT;
				end
			end
			// Framer untouched while it settles
			ST_WAIT: begin
				// Full count elapses before any other access
				if (wait_reg >= WAIT_CYCLES - 1'b1) begin
					addr_reg <= {`TBF_ADDR_W{1'b0}};
					fr_wr_out <= 1'b1;
					fr_addr_out <= {`TBF_ADDR_W{1'b0}};
					fr_data_out <= `TBF_ZERO_DATA;
					state_reg <= ST_ZERO;
				end else begin
					wait_reg <= wait_reg + 1'b1;
				end
			end
			// One write per ack, ascending address
			ST_ZERO: begin
				if (fr_ack_in) begin
					// Last register acked: hand the framer to the host
					if (addr_reg == `TBF_REG_LAST) begin
						fr_wr_out <= 1'b0;
						wait_settings_out <= 1'b1;
						state_reg <= ST_SETTINGS;
					end else begin
						addr_reg <= addr_reg + 1'b1;
						fr_addr_out <= addr_reg + 1'b1;
						// Fallback bit kept in control two while all else cleared
						fr_data_out <= (addr_reg + 1'b1 == `TBF_CTRL_TWO_ADDR) ?
							`TBF_FALLBACK_VAL : `TBF_ZERO_DATA;
					end
				end
			end
			// Host writes its own settings elsewhere, then says so
			ST_SETTINGS: begin
				if (settings_done_in) begin
					wait_settings_out <= 1'b0;
					fr_wr_out <= 1'b1;
					fr_addr_out <= `TBF_CTRL_THREE_ADDR;
					fr_data_out <= `TBF_LINE_INTERFACE_RESET_VAL;
					state_reg <= ST_LINE_INTERFACE_RESET_SET;
				end
			end
			// Line reset set, then the same register cleared
			ST_LINE_INTERFACE_RESET_SET: begin
				if (fr_ack_in) begin
					fr_data_out <= `TBF_ZERO_DATA;
					state_reg <= ST_LINE_INTERFACE_RESET_CLR;
				end
			end
			// Clear write in flight
			ST_LINE_INTERFACE_RESET_CLR: begin
				if (fr_ack_in) begin
					fr_wr_out <= 1'b0;
					// Completion flagged only once the clear is acked
					init_done_out <= 1'b1;
					state_reg <= ST_DONE;
				end
			end
			// A new start restarts the whole sequence at once
			ST_DONE: begin
				if (init_start_in) begin
					init_done_out <= 1'b0;
					fr_wr_out <= 1'b1;
					fr_addr_out <= `TBF_CTRL_TWO_ADDR;
					fr_data_out <= `TBF_FALLBACK_VAL;
					state_reg <= ST_FALLBACK;
				end
			end
			// Unused code falls back to idle rather than locking up
			default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule

// file: src/tbf_consts.vh
// Constants for the TDM bit-clock divider and framer init sequencer.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef TBF_CONSTS_VH
`define TBF_CONSTS_VH
`define TBF_DIV_MSB 12
`define TBF_DIV_LSB 1
`define TBF_PRESCALE_BIT 0
`define TBF_CTRL_W 13
`define TBF_DIV_W 12
`define TBF_PRE_W 4
`define TBF_PRE16_MAX 4'hf
`define TBF_ADDR_W 8
`define TBF_DATA_W 8
`define TBF_CTRL_TWO_ADDR 8'h02
`define TBF_CTRL_THREE_ADDR 8'h03
`define TBF_FALLBACK_VAL 8'h04
`define TBF_LINE_INTERFACE_RESET_VAL 8'h01
`define TBF_ZERO_DATA 8'h00
`define TBF_REG_LAST 8'h3f
`define TBF_CLK_MHZ 100
`define TBF_WAIT_MS 10
`define TBF_WAIT_W 24
`define TBF_WAIT_CYCLES_DEF 24'hf4240
`endif

// file: src/tbf_div.v
// Bit clock generator: rate = clk / ((divider+1) * prescale).
// Assumes the control word is stable or changes only between periods.
`timescale 1ns/1ps
`include "tbf_consts.vh"
module tbf_div (
	// Clock and reset
	input wire clk_in,
	input wire reset_in,
	// Control word
	input wire [`TBF_CTRL_W-1:0] ctrl_in,
	// Bit clock out
	output reg bit_clk_out,
	output reg bit_tick_out
);
	reg [`TBF_DIV_W-1:0] cnt_reg;
	reg [`TBF_PRE_W-1:0] pre_reg;
	reg half_reg;
	wire [`TBF_DIV_W-1:0] div_val = ctrl_in[`TBF_DIV_MSB:`TBF_DIV_LSB];
	wire pre16 = ctrl_in[`TBF_PRESCALE_BIT];
	wire pre_done = !pre16 || (pre_reg == `TBF_PRE16_MAX);
	// Half period rounded down; a zero divider leaves the clock stuck low
	wire [`TBF_DIV_W:0] half_val = ({1'b0, div_val} + 1'b1) >> 1;
	// Prescale then divide; output high then low within each divider period, so clock runs at the divided rate
	always @(posedge clk_in) begin
		if (reset_in) begin
			cnt_reg <= {`TBF_DIV_W{1'b0}};
			pre_reg <= {`TBF_PRE_W{1'b0}};
			half_reg <= 1'b0;
			bit_clk_out <= 1'b0;
			bit_tick_out <= 1'b0;
		end else begin
			bit_tick_out <= 1'b0;
			pre_reg <= pre_done ? {`TBF_PRE_W{1'b0}} : pre_reg + 1'b1;
			if (pre_done) begin
				if (cnt_reg >= div_val) begin
					cnt_reg <= {`TBF_DIV_W{1'b0}};
					bit_tick_out <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
				// High for the first half of the count, low after
				bit_clk_out <= ({1'b0, cnt_reg} < half_val) ? 1'b1 : 1'b0;
			end
		end
	end
endmodule

// file: test/tbf_top_chk.sv
// Port assertions for tbf_top.
// Bound from the bench top file.
`timescale 1ns/1ps
module tbf_top_chk #(parameter PORT_A_E1 = 0, PORT_B_E1 = 0, WAIT_CYCLES = 20) (
	input wire clk_in, reset_in, fr_wr_out, fr_ack_in, wait_settings_out, init_done_out,
	input wire [7:0] fr_addr_out, fr_data_out,
	input wire [1:0] port_e1_out, transmit_bit_clock_out, transmit_serial_data_out,
	input wire [1:0] host_tdm_tx_data_in, host_tdm_rx_data_out, receive_serial_data_in,
	input wire [1:0] host_tdm_rx_clock_out, host_tdm_rx_sync_out, host_tdm_tx_sync_out,
	input wire [1:0] receive_bit_clock_in, receive_frame_sync_in, transmit_frame_sync_in
);
	// Cycles the write strobe has been low, saturating
	logic [23:0] low_cnt;
	always @(posedge clk_in) begin
		if (reset_in || fr_wr_out)
			low_cnt <= 24'h0;
		else if (low_cnt != 24'hffffff)
			low_cnt <= low_cnt + 24'h1;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	property p_hold; fr_wr_out && !fr_ack_in
		|=> fr_wr_out && $stable(fr_addr_out) && $stable(fr_data_out); endproperty
	a_hold: assert property (p_hold) else $error("write moved before ack");
	property p_fb; fr_wr_out && fr_addr_out == 8'h02 |-> fr_data_out == 8'h04; endproperty
	a_fb: assert property (p_fb) else $error("fallback bit lost");
	property p_zero; fr_wr_out && fr_addr_out[7:1] != 7'h01 |-> fr_data_out == 8'h00; endproperty
	a_zero: assert property (p_zero) else $error("nonzero clear");
	property p_lir; fr_wr_out && fr_ack_in && fr_addr_out == 8'h03 && fr_data_out[0]
		|=> fr_wr_out && fr_addr_out == 8'h03 && fr_data_out == 8'h00; endproperty
	a_lir: assert property (p_lir) else $error("line reset not cleared");
	// Clearing must not start before the settle wait has run
	property p_wait; $rose(fr_wr_out) && fr_addr_out == 8'h00
		|-> low_cnt >= WAIT_CYCLES; endproperty
	a_wait: assert property (p_wait) else $error("settle wait too short");
	property p_e1; !$past(reset_in) |-> port_e1_out == {PORT_B_E1[0], PORT_A_E1[0]}; endproperty
	a_e1: assert property (p_e1) else $error("port type wrong");
	property p_pass; !$past(reset_in) |-> transmit_serial_data_out == $past(host_tdm_tx_data_in)
		&& host_tdm_rx_data_out == $past(receive_serial_data_in); endproperty
	a_pass: assert property (p_pass) else $error("data path delay wrong");
	property p_sync; !$past(reset_in) |-> host_tdm_rx_clock_out == $past(receive_bit_clock_in)
		&& host_tdm_rx_sync_out == $past(receive_frame_sync_in)
		&& host_tdm_tx_sync_out == $past(transmit_frame_sync_in); endproperty
	a_sync: assert property (p_sync) else $error("clock or sync path wrong");
	// Port B divider is held at 25, a 26-cycle period, for the whole run
	property p_rate; $rose(transmit_bit_clock_out[1]) |-> ##26 $rose(transmit_bit_clock_out[1]);
	endproperty
	a_rate: assert property (p_rate) else $error("bit clock period wrong");
	cover property (wait_settings_out);
	cover property (init_done_out);
	cover property (fr_ack_in && fr_addr_out == 8'h3f);
endmodule

// file: test/tbf_framer_model.sv
// Framer stand-in: register file behind a write/ack port.
// Assumes one write held until each ack.
`timescale 1ns/1ps
module tbf_framer_model (
	input wire clk_in,
	input wire slow_in,
	input wire fr_wr_in,
	input wire [7:0] fr_addr_in,
	input wire [7:0] fr_data_in,
	output logic fr_ack_out = 1'b0,
	output logic [1:0] rx_data_out,
	output logic [1:0] rx_clk_out,
	output logic [1:0] rx_sync_out,
	output logic [1:0] tx_sync_out
);
	logic [7:0] regs [0:63];
	logic [3:0] cnt = 4'h0;
	integer n_wr = 0, line_interface_reset = 0, gap = 0;
	// Slow mode acks one cycle in four to stretch writes
	always @(posedge clk_in) begin
		cnt <= cnt + 4'h1;
		fr_ack_out <= fr_wr_in && !fr_ack_out && (!slow_in || cnt[1:0] == 2'h3);
		if (!fr_wr_in && n_wr == 1)
			gap <= gap + 1;
		if (fr_wr_in && fr_ack_out) begin
			regs[fr_addr_in[5:0]] <= fr_data_in;
			n_wr <= n_wr + 1;
			if (fr_addr_in == 8'h03 && fr_data_in[0])
				line_interface_reset <= line_interface_reset + 1;
		end
	end
	// Framer always drives the rx clock and both syncs
	assign rx_clk_out = {2{cnt[0]}};
	assign rx_data_out = cnt[2:1];
	assign rx_sync_out = {2{cnt == 4'h0}};
	assign tx_sync_out = {2{cnt == 4'h8}};
endmodule

// file: test/tbf_top_tb_top.sv
// Bench for tbf_top: bit clock periods and framer init runs.
// Assumes the framer model and checker are compiled first.
`timescale 1ns/1ps
module tbf_top_tb_top;
	logic clk_in = 1'b0, reset_in = 1'b1, init_start_in = 1'b0, settings_done_in = 1'b0;
	logic slow = 1'b1, fr_ack_in, fr_wr_out, wait_settings_out, init_done_out;
	logic [12:0] ctrl_a_in = 13'h032, ctrl_b_in = 13'h032;
	logic [1:0] host_tdm_tx_data_in = 2'h0, port_e1_out, transmit_bit_clock_out;
	logic [1:0] receive_serial_data_in, receive_bit_clock_in;
	logic [1:0] receive_frame_sync_in, transmit_frame_sync_in;
	logic [7:0] fr_addr_out, fr_data_out;
	logic [12:0] cv [4] = '{13'h032, 13'h026, 13'h003, 13'h1ffe};
	int pv [4] = '{26, 20, 32, 4096};
	integer fail_count = 0, total_checks = 0, cyc = 0, t0, k;
	tbf_top #(.PORT_A_E1(0), .PORT_B_E1(1), .WAIT_CYCLES(24'h000014)) i_tbf_top (.*,
		.host_tdm_rx_data_out(), .host_tdm_rx_sync_out(), .host_tdm_tx_sync_out(),
		.host_tdm_rx_clock_out(), .transmit_serial_data_out());
	tbf_framer_model i_tbf_framer_model (.clk_in(clk_in), .slow_in(slow),
		.fr_wr_in(fr_wr_out), .fr_addr_in(fr_addr_out), .fr_data_in(fr_data_out),
		.fr_ack_out(fr_ack_in), .rx_data_out(receive_serial_data_in),
		.rx_clk_out(receive_bit_clock_in), .rx_sync_out(receive_frame_sync_in),
		.tx_sync_out(transmit_frame_sync_in));
	initial forever #5 clk_in = ~clk_in;
	// Hang guard, well above the planned run
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			conclude;
		end
	end
	// Changing tx data keeps the data path busy
	always @(negedge clk_in) host_tdm_tx_data_in <= cyc[1:0];
	task chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("checks %0d fails %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Cycles between rises of port A bit clock
	task period(input logic [12:0] c, input int exp);
		@(negedge clk_in) ctrl_a_in = c;
		repeat (2) @(posedge transmit_bit_clock_out[0]);
		@(negedge clk_in) t0 = cyc;
		@(posedge transmit_bit_clock_out[0]);
		@(negedge clk_in) chk(cyc - t0, exp);
	endtask
	// One init pass; a start request while waiting must be ignored
	task init_run(input logic s, input int nw);
		@(negedge clk_in) slow = s;
		init_start_in = 1'b1;
		@(negedge clk_in) init_start_in = 1'b0;
		for (k = 0; wait_settings_out !== 1'b1 && k < 2000; k++) @(negedge clk_in);
		init_start_in = 1'b1;
		repeat (3) @(negedge clk_in);
		chk(fr_wr_out, 1'b0);
		init_start_in = 1'b0;
		settings_done_in = 1'b1;
		for (k = 0; init_done_out !== 1'b1 && k < 100; k++) @(negedge clk_in);
		settings_done_in = 1'b0;
		chk(i_tbf_framer_model.n_wr, nw);
		chk(i_tbf_framer_model.line_interface_reset, nw / 67);
		chk(i_tbf_framer_model.gap >= 20, 1);
		for (k = 0; k < 64; k++) chk(i_tbf_framer_model.regs[k], k == 2 ? 8'h04 : 8'h00);
		$display("test init pass done");
	endtask
	initial begin
		repeat (12) @(negedge clk_in);
		reset_in = 1'b0;
		repeat (2) @(negedge clk_in);
		chk(port_e1_out, 2'h2);
		chk({fr_wr_out, init_done_out}, 2'h0);
		$display("test reset done");
		foreach (cv[i]) period(cv[i], pv[i]);
		$display("test bit clock done");
		init_run(1'b1, 67);
		init_run(1'b0, 134);
		conclude;
	end
endmodule
bind tbf_top tbf_top_chk #(.PORT_A_E1(PORT_A_E1), .PORT_B_E1(PORT_B_E1),
	.WAIT_CYCLES(WAIT_CYCLES)) i_tbf_top_chk (.*);
